//--- src/dmp_pkg.sv
/*
  Constants shared by the dual-modulus prescaler: register offsets, field
  positions, values after reset and the phase lengths of the divider.
  Assumes a 32-bit AXI4-Lite register bus and one 125 MHz system clock.
*/
package dmp_pkg;
  // Register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register fields
  localparam int unsigned CTRL_SET_BIT = 0;
  localparam int unsigned CTRL_TEN_BIT = 1;
  localparam logic CTRL_SET_RST = 1'h0;
  localparam logic CTRL_TEN_RST = 1'h0;
  // Status register fields
  localparam int unsigned STAT_STAGE_LSB = 0;
  localparam int unsigned STAT_TEN_BIT = 4;
  localparam int unsigned STAT_RUN_LSB = 8;
  localparam int unsigned STAT_SET_BIT = 16;
  localparam int unsigned STAT_HOLD_BIT = 17;
  // Divider stage values
  localparam logic [3:0] STAGES_SET = 4'hf;
  localparam logic [3:0] RUN_FIRST = 4'h1;
  localparam logic [3:0] HIGH_LEN_ELEVEN = 4'h6;
  localparam logic [3:0] HIGH_LEN_TEN = 4'h5;
  localparam logic [3:0] LOW_LEN = 4'h5;
endpackage

//--- src/dmp_prescaler.sv
/*
  Dual-modulus prescaler: divides a sampled count clock pin by eleven or ten
  with a three-stage shift counter feeding a toggle stage, plus an AXI4-Lite
  slave for software master-set, forced divide-by-ten and status readback.
  Assumes all prescaler pins are asynchronous to clock and that the count
  clock pin runs at no more than a quarter of the system clock rate.
*/
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Behaviour
// - Three shift stages drive a toggling output stage
// - Eleven mode: output high six, low five
// - Ten mode: output high five, low five
// - Either select high gives divide by ten
// - Cycle length fixed once output rises
// - Alternate-level output mirrors divided output
// - Master set forces every stage high
module dmp_prescaler (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic count_input_clock,
  input wire logic count_enable_n,
  input wire logic modulus_select_a,
  input wire logic modulus_select_b,
  input wire logic master_set_async,
  output logic divided_output,
  output logic divided_output_n,
  output logic divided_output_alt_level,
  input wire logic [dmp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dmp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dmp_pkg::*;

  typedef struct packed {
    logic [2:0] cp_sync;
    logic [1:0] ms_sync;
    logic [1:0] ce_sync;
    logic [1:0] ma_sync;
    logic [1:0] mb_sync;
    logic [3:0] stages;
    logic out_n;
    logic alt;
    logic ten_cycle;
    logic [3:0] run_len;
    logic ctrl_set;
    logic ctrl_ten;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dmp_state_t;

  dmp_state_t st;
  dmp_state_t next_st;
  logic q1;
  logic q2;
  logic q3;
  logic q4;
  logic set_now;
  logic hold_now;
  logic tick;
  logic commit_pt;
  logic sel_ten;
  logic [3:0] next_stages;

  // Word decode shared by read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_CTRL) || (a == OFF_STATUS);
  endfunction

  // Divider view of the synchronised pins
  assign q1 = st.stages[0];
  assign q2 = st.stages[1];
  assign q3 = st.stages[2];
  assign q4 = st.stages[3];
  assign set_now = st.ms_sync[1] | st.ctrl_set;
  assign hold_now = st.ce_sync[1];
  assign tick = st.cp_sync[1] & ~st.cp_sync[2] & ~hold_now & ~set_now;
  assign commit_pt = q1 & q2 & ~q3 & ~q4;
  assign sel_ten = st.ma_sync[1] | st.mb_sync[1] | st.ctrl_ten;

  // Shift counter feedback and toggle stage
  always_comb begin
    next_stages[1] = q1;
    next_stages[2] = q2;
    next_stages[0] = ~q3 & ~(q1 & q2 & ~q3 & (q4 | sel_ten));
    next_stages[3] = q4 ^ (q2 & ~q3);
  end

  // Outputs straight from flip-flops; the bus ready signals are gated from them
  assign divided_output = q4;
  assign divided_output_n = st.out_n;
  assign divided_output_alt_level = st.alt;
  assign s_axi_awready = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready = ~st.w_held & ~st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // Next-state logic for divider and bus slave
  always_comb begin
    next_st = st;
    next_st.cp_sync = {st.cp_sync[1:0], count_input_clock};
    next_st.ms_sync = {st.ms_sync[0], master_set_async};
    next_st.ce_sync = {st.ce_sync[0], count_enable_n};
    next_st.ma_sync = {st.ma_sync[0], modulus_select_a};
    next_st.mb_sync = {st.mb_sync[0], modulus_select_b};
    if (set_now) begin
      next_st.stages = STAGES_SET;
      next_st.ten_cycle = 1'b0;
      next_st.run_len = RUN_FIRST;
    end else if (tick) begin
      next_st.stages = next_stages;
      if (commit_pt) begin
        next_st.ten_cycle = sel_ten;
      end
      if (next_stages[3] != q4) begin
        next_st.run_len = RUN_FIRST;
      end else begin
        next_st.run_len = 4'(st.run_len + 4'h1);
      end
    end
    next_st.out_n = ~next_st.stages[3];
    next_st.alt = next_st.stages[3];
    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st.aw_addr == OFF_CTRL && st.wstrb[0]) begin
        next_st.ctrl_set = st.wdata[CTRL_SET_BIT];
        next_st.ctrl_ten = st.wdata[CTRL_TEN_BIT];
      end
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read channel: one-cycle answer after address taken
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_st.rdata = 32'h0;
      if (s_axi_araddr == OFF_CTRL) begin
        next_st.rdata[CTRL_SET_BIT] = st.ctrl_set;
        next_st.rdata[CTRL_TEN_BIT] = st.ctrl_ten;
      end else if (s_axi_araddr == OFF_STATUS) begin
        next_st.rdata[STAT_STAGE_LSB +: 4] = st.stages;
        next_st.rdata[STAT_TEN_BIT] = st.ten_cycle;
        next_st.rdata[STAT_RUN_LSB +: 4] = st.run_len;
        next_st.rdata[STAT_SET_BIT] = set_now;
        next_st.rdata[STAT_HOLD_BIT] = hold_now;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Synchronous reset leaves the divider in the set state
    if (!rst_n) begin
      next_st = '0;
      next_st.stages = STAGES_SET;
      next_st.out_n = ~STAGES_SET[3];
      next_st.alt = STAGES_SET[3];
      next_st.run_len = RUN_FIRST;
      next_st.ctrl_set = CTRL_SET_RST;
      next_st.ctrl_ten = CTRL_TEN_RST;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    st <= next_st;
  end

  // Checks on the divider behaviour; all of them sleep while reset is low,
  // and the ones that look back one edge see the set state just after it
  default clocking dmp_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence commit_tick_s;
    tick && commit_pt;
  endsequence

  // Output fall, split by the cycle length committed at the last rise;
  // the mode is folded into the sequence so that no logical and is needed
  sequence eleven_fall_s;
    $fell(q4) && !$past(st.ten_cycle);
  endsequence

  sequence ten_fall_s;
    $fell(q4) && $past(st.ten_cycle);
  endsequence

  shift_chain_a: assert property (tick |=> q2 == $past(q1) && q3 == $past(q2))
    else $error("shift stages did not advance");
  toggle_stage_a: assert property (tick && q2 && !q3 |=> q4 != $past(q4))
    else $error("output stage missed its toggle");
  eleven_high_a: assert property (
      eleven_fall_s |-> $past(st.run_len) == HIGH_LEN_ELEVEN)
    else $error("eleven mode high phase length wrong");
  ten_high_a: assert property (
      ten_fall_s |-> $past(st.run_len) == HIGH_LEN_TEN)
    else $error("ten mode high phase length wrong");
  low_len_a: assert property ($rose(q4) && $past(!set_now)
      |-> $past(st.run_len) == LOW_LEN)
    else $error("low phase length wrong");
  mode_pick_a: assert property (commit_tick_s |=> q1 == !$past(sel_ten) && q4)
    else $error("modulus selection not applied");
  // A master set may restart the cycle at any time, so it is left out here
  mode_frozen_a: assert property (
      q4 && $past(q4) && $past(!set_now) |-> $stable(st.ten_cycle))
    else $error("cycle length changed while output high");
  alt_level_a: assert property (divided_output_alt_level == divided_output)
    else $error("alternate level output differs");
  master_set_a: assert property (set_now |=> st.stages == STAGES_SET [*1])
    else $error("master set did not force stages high");
  count_hold_a: assert property (hold_now && !set_now |=> $stable(st.stages))
    else $error("stages moved while count enable high");
  complement_a: assert property (divided_output_n == !divided_output)
    else $error("complementary output not inverse");

  // Independent copy of the count table as {Q4, Q3, Q2, Q1}: the stages must
  // walk it one step per counted edge, so a wrong feedback term shows up here
  // even when the phase lengths happen to come out right. Codes off the table
  // are never reached from the set state and expect the set state back.
  function automatic logic [3:0] seq_after(input logic [3:0] s, input logic ten);
    logic [3:0] n;
    n = STAGES_SET;
    case (s)
      4'hf: n = 4'he;
      4'he: n = 4'hc;
      4'hc: n = 4'h8;
      4'h8: n = 4'h9;
      4'h9: n = 4'hb;
      4'hb: n = 4'h6;
      4'h6: n = 4'h4;
      4'h4: n = 4'h0;
      4'h0: n = 4'h1;
      4'h1: n = 4'h3;
      4'h3: n = ten ? 4'he : 4'hf;
      default: n = STAGES_SET;
    endcase
    return n;
  endfunction

  table_step_a: assert property (
      tick |=> st.stages == seq_after($past(st.stages), $past(sel_ten)))
    else $error("count state left the count table");
  idle_freeze_a: assert property (!tick && !set_now |=> $stable(st.stages))
    else $error("stages moved without a counted edge");
  mode_pins_a: assert property (
      tick && commit_pt && (st.ma_sync[1] || st.mb_sync[1]) |=> !q1 && q4)
    else $error("select pin did not give divide by ten");
  hold_run_a: assert property (hold_now && !set_now |=> $stable(st.run_len))
    else $error("phase count moved while count enable high");
  set_outputs_a: assert property (set_now |=> divided_output && !divided_output_n)
    else $error("outputs not high after master set");
  set_restart_a: assert property (set_now |=> st.run_len == RUN_FIRST && !st.ten_cycle)
    else $error("master set did not restart the eleven cycle");

  // Bus slave handshakes: one answer per request, no new request meanwhile
  write_answer_a: assert property (st.aw_held && st.w_held |=> s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  write_gap_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_gap_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule // dmp_prescaler

//--- verification/dmp_far_end.sv
/* Far-side counting logic model: free-running count clock, select A steered
   on the divided output's rise and again on its fall.
   Assumes one system clock, sync rst_n. */
`timescale 1ns/1ns
module dmp_far_end (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic want_ten,
  input wire logic divided_output,
  output logic count_input_clock,
  output logic modulus_select_a
);
  logic [1:0] ph;
  logic last;
  // Known levels before the first edge
  initial begin
    {ph, last, count_input_clock, modulus_select_a} = 5'h0;
  end
  // Count clock two periods high, two low; select changed only after a rise or a fall
  always @(posedge clock) begin
    last <= divided_output;
    ph <= rst_n ? ph + 2'h1 : 2'h0;
    count_input_clock <= ph[1];
    if (!rst_n) modulus_select_a <= 1'h0;
    else if (divided_output && !last) modulus_select_a <= want_ten;
    else if (!divided_output && last) modulus_select_a <= want_ten;
  end
endmodule // dmp_far_end

//--- verification/tb.sv
/* Self-checking bench for the prescaler: modes, glitch, set, hold, bus.
   Assumes the far-end model drives the count clock and select A. */
`timescale 1ns/1ns
module tb;
  import dmp_pkg::*;
  logic clock = 1'h0, rst_n = 1'h0, count_enable_n = 1'h0, want_ten = 1'h0;
  logic modulus_select_b = 1'h0, master_set_async = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic count_input_clock, modulus_select_a, divided_output, divided_output_n;
  logic divided_output_alt_level, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bres, rres;
  int n_errors = 0, comparisons = 0, pins = 0;
  // Clock and count-edge tally
  always #4 clock = ~clock;
  always @(posedge count_input_clock) pins++;
  dmp_far_end far (.clock, .rst_n, .want_ten, .divided_output, .count_input_clock,
    .modulus_select_a);
  dmp_prescaler uut (.clock, .rst_n, .count_input_clock, .count_enable_n, .modulus_select_a,
    .modulus_select_b, .master_set_async, .divided_output, .divided_output_n,
    .divided_output_alt_level, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bit ap;
    bit wp;
    ap = 1'h1;
    wp = 1'h1;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (ap | wp) begin
      @(posedge clock);
      if (s_axi_awready === 1'h1) ap = 1'h0;
      if (s_axi_wready === 1'h1) wp = 1'h0;
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'h1);
    bres = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clock); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock); while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    rres = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Count edges in the high and low phase of the next output cycle
  task automatic meas(input int h, input int l, input bit g);
    int c;
    @(posedge divided_output);
    c = pins;
    if (g) begin
      repeat (8) @(posedge clock);
      modulus_select_b <= 1'h1;
      repeat (4) @(posedge clock);
      modulus_select_b <= 1'h0;
    end
    @(negedge divided_output);
    chk("high", pins - c, h);
    c = pins;
    #1 chk("inv", divided_output_n, !divided_output);
    chk("alt", divided_output_alt_level, divided_output);
    @(posedge divided_output);
    chk("low", pins - c, l);
  endtask
  task automatic t_modes;
    meas(6, 5, 1'h0);
    want_ten <= 1'h1;
    meas(5, 5, 1'h0);
    want_ten <= 1'h0;
    modulus_select_b <= 1'h1;
    meas(5, 5, 1'h0);
    modulus_select_b <= 1'h0;
    meas(6, 5, 1'h1);
  endtask
  task automatic t_force;
    wr(OFF_CTRL, 32'h2);
    chk("bresp", bres, RESP_OKAY);
    rd(OFF_CTRL);
    chk("ctrl", rdat, 32'h2);
    @(posedge divided_output);
    meas(5, 5, 1'h0);
    rd(OFF_STATUS);
    chk("ten", rdat[STAT_TEN_BIT], 1'h1);
    wr(OFF_CTRL, 32'h0);
    wr(4'h8, 32'h2);
    chk("wbad", bres, RESP_SLVERR);
    rd(4'hc);
    chk("rresp", rres, RESP_SLVERR);
    chk("rbad", rdat, 32'h0);
  endtask
  task automatic t_set_hold;
    logic [31:0] c;
    master_set_async <= 1'h1;
    repeat (6) @(posedge clock);
    rd(OFF_STATUS);
    chk("set", {rdat[STAT_SET_BIT], rdat[3:0], divided_output}, 6'h3f);
    master_set_async <= 1'h0;
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STATUS);
    chk("swset", {rdat[STAT_SET_BIT], rdat[3:0]}, 5'h1f);
    wr(OFF_CTRL, 32'h0);
    repeat (30) @(posedge clock);
    count_enable_n <= 1'h1;
    repeat (4) @(posedge clock);
    rd(OFF_STATUS);
    c = rdat;
    repeat (40) @(posedge clock);
    rd(OFF_STATUS);
    chk("hold", {rdat[STAT_HOLD_BIT], rdat[11:0]}, {1'h1, c[11:0]});
    count_enable_n <= 1'h0;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    t_modes;
    t_force;
    t_set_hold;
    print_verdict;
  end
  // Hang guard
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end
endmodule // tb
